// ---- hw/ufg_level_sel.sv ----
// Resolves the flow thresholds and FIFO trigger levels actually in use.
`timescale 1ns/1ps
module ufg_level_sel
    import ufg_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Programmed values.
    input  wire logic [7:0]    flow,
    input  wire logic [7:0]    trig,
    input  wire ufg_fcr_lvl_t  fifo_control_reg,
    // Resolved levels.
    output ufg_levels_t        levels
);

    ufg_levels_t levels_r;
    ufg_levels_t levels_nxt;
    wire         flow_zero = (flow == RST_FLOW);

    always_comb
    begin
        levels_nxt = levels_r;
        if (flow_zero)
        begin
            levels_nxt.halt   = fifo_control_reg.rx;
            levels_nxt.resume = fifo_control_reg.rx;
        end
        else
        begin
            levels_nxt.halt   = ufg_nib_level(flow[FLOW_HALT_LSB +: NIB_W]);
            levels_nxt.resume = ufg_nib_level(flow[FLOW_RESUME_LSB +: NIB_W]);
        end
        levels_nxt.rx_trig = ufg_pick(trig[TRIG_RX_LSB +: NIB_W], fifo_control_reg.rx);
        levels_nxt.tx_trig = ufg_pick(trig[TRIG_TX_LSB +: NIB_W], fifo_control_reg.tx);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            levels_r <= '{RST_LEVEL, RST_LEVEL, RST_LEVEL, RST_LEVEL};
        else
            levels_r <= levels_nxt;
    end

    assign levels = levels_r;

endmodule

// ---- hw/ufg_pin_sync.sv ----
// Two-stage pin synchroniser with previous-sample change detection.
`timescale 1ns/1ps
module ufg_pin_sync #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Raw pins and synchronised view.
    input  wire logic [W-1:0] pin_raw,
    output logic      [W-1:0] pin_sync,
    output logic      [W-1:0] pin_change
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            meta_r <= pin_raw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign pin_sync   = sync_r;
    assign pin_change = sync_r ^ prev_r;

endmodule

// ---- hw/ufg_pkg.sv ----
// Shared constants, types and helper functions of the extended register bank.
package ufg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port geometry and register offsets.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NIB_W  = 4;
    localparam int LVL_W  = 6;
    localparam int CNT_W  = 7;
    localparam int PIN_W  = 8;

    localparam logic [ADDR_W-1:0] OFS_SCRATCH = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FLOW    = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_TRIG    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_TXSPACE = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_RXFILL  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PINDIR  = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_PINLVL  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_PINIRQ  = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and field positions.
    localparam logic [DATA_W-1:0] RST_SCRATCH = 8'h00;
    localparam logic [DATA_W-1:0] RST_FLOW    = 8'h00;
    localparam logic [DATA_W-1:0] RST_TRIG    = 8'h00;
    localparam logic [DATA_W-1:0] RST_PINDIR  = 8'h00;
    localparam logic [DATA_W-1:0] RST_PINOUT  = 8'h00;
    localparam logic [DATA_W-1:0] RST_PINIRQ  = 8'h00;
    localparam logic [LVL_W-1:0]  RST_LEVEL   = 6'h00;

    localparam int FLOW_HALT_LSB   = 0;
    localparam int FLOW_RESUME_LSB = 4;
    localparam int TRIG_TX_LSB     = 0;
    localparam int TRIG_RX_LSB     = 4;
    localparam int PFC_LATCH       = 0;
    localparam int PFC_HI_MODEM    = 1;
    localparam int PFC_LO_MODEM    = 2;

    ////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ufg_req_t;

    typedef struct packed {
        logic [2:0] pin_function_control;
        logic       enhanced_function_enable_bit;
        logic       threshold_access_bit;
        logic       modem_status_irq_enable;
    } ufg_ctrl_t;

    typedef struct packed {
        logic [CNT_W-1:0] tx_space;
        logic [CNT_W-1:0] rx_fill;
    } ufg_fifo_t;

    typedef struct packed {
        logic [LVL_W-1:0] rx;
        logic [LVL_W-1:0] tx;
    } ufg_fcr_lvl_t;

    typedef struct packed {
        logic [LVL_W-1:0] halt;
        logic [LVL_W-1:0] resume;
        logic [LVL_W-1:0] rx_trig;
        logic [LVL_W-1:0] tx_trig;
    } ufg_levels_t;

    ////////////////////////////////////////////////////////////////////////
    // A nibble N stands for a level of four times N characters.
    function automatic logic [LVL_W-1:0] ufg_nib_level(
        input logic [NIB_W-1:0] nib
    );
        return {nib, 2'b00};
    endfunction

    // A zero nibble falls back to the level chosen in the FIFO control reg.
    function automatic logic [LVL_W-1:0] ufg_pick(
        input logic [NIB_W-1:0] nib,
        input logic [LVL_W-1:0] fcr_level
    );
        return (nib == 4'h0) ? fcr_level : ufg_nib_level(nib);
    endfunction

endpackage

// ---- hw/ufg_regs.sv ----
// Per-channel scratch, threshold, FIFO level and pin register bank.
//
// Functional notes
// - Eight-bit scratch register reads back what was written, no side effect.
// - Flow threshold: halt level in low nibble, resume level in high nibble.
// - Each flow nibble selects zero to sixty characters in steps of four.
// - All-zero flow threshold means the FIFO-control receive trigger level is used for both halt and resume.
// - Flow threshold writable only with enhanced enable and access bit set.
// - No check that halt exceeds resume; any value is stored.
// - Trigger register: receive level high nibble, transmit level low.
// - Nonzero trigger nibble N means a level of four times N.
// - Trigger register writable only with both access bits set.
// - Per direction, zero nibble uses FIFO-control level, nonzero overrides.
// - Read-only transmit free space, zero to 64, bit seven zero.
// - Read-only receive fill count, zero to 64, bit seven zero.
// - Direction bit zero makes pin input, one makes it output.
// - Reading pin level returns present state of all eight pins, captured value for latched input bits.
// - Writing pin level drives output pins; input bits have no effect.
// - Change enable lets an input pin change raise the interrupt.
// - Modem-function nibble ignores change enables, uses modem irq enable.
// - Function bit one switches pins 7-4, bit two pins 3-0, to modem use.
// - Latching keeps value and interrupt until read; else change self-clears.
`timescale 1ns/1ps
module ufg_regs
    import ufg_pkg::*;
(
    // Clock and reset.
    input  wire logic         CLK,
    input  wire logic         RST_N,
    // Register port.
    input  wire ufg_req_t     REG_REQ,
    output logic [DATA_W-1:0] REG_RDATA,
    // Control bits held elsewhere in the channel.
    input  wire ufg_ctrl_t    CTRL,
    // FIFO side.
    input  wire ufg_fifo_t    FIFO_STAT,
    input  wire ufg_fcr_lvl_t FCR_LVL,
    output ufg_levels_t       LEVELS,
    // General-purpose pins.
    input  wire logic [PIN_W-1:0] GPIO_IN,
    output logic [PIN_W-1:0]  GPIO_OUT,
    output logic [PIN_W-1:0]  GPIO_OE,
    // Pin-change interrupt request.
    output logic              GPIO_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [DATA_W-1:0] scratch_byte_r;
    logic [DATA_W-1:0] flow_threshold_r;
    logic [DATA_W-1:0] fifo_trigger_level_r;
    logic [PIN_W-1:0]  pin_direction_r;
    logic [PIN_W-1:0]  pin_out_r;
    logic [PIN_W-1:0]  pin_change_irq_enable_r;
    logic [PIN_W-1:0]  latch_pend_r;
    logic [PIN_W-1:0]  latch_val_r;
    logic [PIN_W-1:0]  ref_level_r;
    logic [2:0]        settle_r;
    logic [DATA_W-1:0] rdata_r;
    logic              irq_r;

    logic [DATA_W-1:0] rdata_nxt;
    logic [PIN_W-1:0]  latch_pend_nxt;
    logic [PIN_W-1:0]  latch_val_nxt;
    logic [PIN_W-1:0]  ref_level_nxt;
    logic              irq_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and level selection.
    logic [PIN_W-1:0] pin_sync;
    logic [PIN_W-1:0] pin_change;

    ufg_pin_sync #(
        .W          (PIN_W)
    ) u_pin_sync (
        .clk        (CLK),
        .rst_n      (RST_N),
        .pin_raw    (GPIO_IN),
        .pin_sync   (pin_sync),
        .pin_change (pin_change)
    );

    ufg_level_sel u_level_sel (
        .clk    (CLK),
        .rst_n  (RST_N),
        .flow   (flow_threshold_r),
        .trig   (fifo_trigger_level_r),
        .fifo_control_reg    (FCR_LVL),
        .levels (LEVELS)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    wire hit_scratch = (REG_REQ.addr == OFS_SCRATCH);
    wire hit_flow    = (REG_REQ.addr == OFS_FLOW);
    wire hit_trig    = (REG_REQ.addr == OFS_TRIG);
    wire hit_txspace = (REG_REQ.addr == OFS_TXSPACE);
    wire hit_rxfill  = (REG_REQ.addr == OFS_RXFILL);
    wire hit_pindir  = (REG_REQ.addr == OFS_PINDIR);
    wire hit_pinlvl  = (REG_REQ.addr == OFS_PINLVL);
    wire hit_pinirq  = (REG_REQ.addr == OFS_PINIRQ);

    // Threshold registers are locked unless both enables are set.
    wire thr_access = CTRL.enhanced_function_enable_bit
                    & CTRL.threshold_access_bit;

    wire wr_scratch = REG_REQ.wr & hit_scratch;
    wire wr_flow    = REG_REQ.wr & hit_flow & thr_access;
    wire wr_trig    = REG_REQ.wr & hit_trig & thr_access;
    wire wr_pindir  = REG_REQ.wr & hit_pindir;
    wire wr_pinlvl  = REG_REQ.wr & hit_pinlvl;
    wire wr_pinirq  = REG_REQ.wr & hit_pinirq;
    wire rd_pinlvl  = REG_REQ.rd & hit_pinlvl;

    ////////////////////////////////////////////////////////////////////////
    // Pin mode decode.
    wire latch_mode = CTRL.pin_function_control[PFC_LATCH];
    wire hi_modem   = CTRL.pin_function_control[PFC_HI_MODEM];
    wire lo_modem   = CTRL.pin_function_control[PFC_LO_MODEM];

    wire [PIN_W-1:0] input_mask = ~pin_direction_r;

    // A modem-function nibble takes its enable from the modem irq bit.
    wire [3:0] en_hi = hi_modem ? {4{CTRL.modem_status_irq_enable}}
                                : pin_change_irq_enable_r[7:4];
    wire [3:0] en_lo = lo_modem ? {4{CTRL.modem_status_irq_enable}}
                                : pin_change_irq_enable_r[3:0];
    wire [PIN_W-1:0] irq_enable = {en_hi, en_lo};

    ////////////////////////////////////////////////////////////////////////
    // Change tracking for input pins.
    // Latching mode keeps the first changed value until the level register
    // is read. Non-latching mode compares against the level seen at the
    // last read, so a pin that returns to that level drops its request.
    // The sync chain leaves reset at zero, so a pin that idles high would
    // look like an edge; changes count only once the chain holds the pin.
    wire [PIN_W-1:0] new_change =
        pin_change & input_mask & {PIN_W{settle_r[2]}};
    wire [PIN_W-1:0] nonlatch_pend =
        (pin_sync ^ ref_level_r) & input_mask & {PIN_W{settle_r[2]}};
    wire [PIN_W-1:0] pend_eff =
        latch_mode ? (latch_pend_r & input_mask) : nonlatch_pend;

    // Latched input bits report the captured value, others the live pin.
    wire [PIN_W-1:0] show_latched = latch_pend_r & input_mask
                                  & {PIN_W{latch_mode}};
    wire [PIN_W-1:0] pin_level_view =
        (show_latched & latch_val_r) | (~show_latched & pin_sync);

    always_comb
    begin
        latch_pend_nxt = latch_pend_r;
        latch_val_nxt  = latch_val_r;
        ref_level_nxt  = ref_level_r;
        // The read clears first so that a change in the same cycle wins.
        if (rd_pinlvl)
        begin
            latch_pend_nxt = '0;
            ref_level_nxt  = pin_sync;
        end
        if (!settle_r[2])
        begin
            ref_level_nxt = pin_sync;
        end
        if (latch_mode)
        begin
            for (int i = 0; i < PIN_W; i++)
            begin
                if (new_change[i] && !latch_pend_r[i])
                begin
                    latch_pend_nxt[i] = 1'b1;
                    latch_val_nxt[i]  = pin_sync[i];
                end
                else if (new_change[i] && rd_pinlvl)
                begin
                    latch_pend_nxt[i] = 1'b1;
                    latch_val_nxt[i]  = pin_sync[i];
                end
            end
        end
    end

    assign irq_nxt = |(pend_eff & irq_enable);

    ////////////////////////////////////////////////////////////////////////
    // Read data mux. Unmapped offsets read as zero.
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (REG_REQ.rd)
        begin
            case (REG_REQ.addr)
                OFS_SCRATCH: rdata_nxt = scratch_byte_r;
                OFS_FLOW:    rdata_nxt = flow_threshold_r;
                OFS_TRIG:    rdata_nxt = fifo_trigger_level_r;
                OFS_TXSPACE: rdata_nxt = {1'b0, FIFO_STAT.tx_space};
                OFS_RXFILL:  rdata_nxt = {1'b0, FIFO_STAT.rx_fill};
                OFS_PINDIR:  rdata_nxt = pin_direction_r;
                OFS_PINLVL:  rdata_nxt = pin_level_view;
                OFS_PINIRQ:  rdata_nxt = pin_change_irq_enable_r;
                default:     rdata_nxt = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written registers.
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scratch_byte_r       <= RST_SCRATCH;
            flow_threshold_r     <= RST_FLOW;
            fifo_trigger_level_r <= RST_TRIG;
        end
        else
        begin
            if (wr_scratch)
                scratch_byte_r <= REG_REQ.wdata;
            // Stored as written, even if halt is not above resume.
            if (wr_flow)
                flow_threshold_r <= REG_REQ.wdata;
            if (wr_trig)
                fifo_trigger_level_r <= REG_REQ.wdata;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pin_direction_r         <= RST_PINDIR;
            pin_out_r               <= RST_PINOUT;
            pin_change_irq_enable_r <= RST_PINIRQ;
        end
        else
        begin
            if (wr_pindir)
                pin_direction_r <= REG_REQ.wdata;
            // The value is kept for every bit; only output pins show it.
            if (wr_pinlvl)
                pin_out_r <= REG_REQ.wdata;
            if (wr_pinirq)
                pin_change_irq_enable_r <= REG_REQ.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Change state, read data and interrupt.
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            latch_pend_r <= '0;
            latch_val_r  <= '0;
            ref_level_r  <= '0;
            settle_r     <= '0;
            rdata_r      <= '0;
            irq_r        <= 1'b0;
        end
        else
        begin
            latch_pend_r <= latch_pend_nxt;
            latch_val_r  <= latch_val_nxt;
            ref_level_r  <= ref_level_nxt;
            settle_r     <= {settle_r[1:0], 1'b1};
            rdata_r      <= rdata_nxt;
            irq_r        <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. Pins that are inputs are never driven.
    assign REG_RDATA = rdata_r;
    assign GPIO_OUT  = pin_out_r;
    assign GPIO_OE   = pin_direction_r;
    assign GPIO_IRQ  = irq_r;

endmodule

// ---- testbench/tb.sv ----
// Self-checking bench of the extended register bank.
`timescale 1ns/1ps
module tb;
    import ufg_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n;
    ufg_req_t          req;
    logic [DATA_W-1:0] rdata;
    ufg_ctrl_t         ctrl;
    ufg_fifo_t         fifo;
    ufg_fcr_lvl_t      fifo_control_reg;
    ufg_levels_t       levels;
    logic [PIN_W-1:0]  ext;
    logic [PIN_W-1:0]  pins;
    logic [PIN_W-1:0]  gout;
    logic [PIN_W-1:0]  goe;
    logic              irq;
    logic [DATA_W-1:0] d;
    int                err_total = 0;
    int                compares = 0;

    always #50 clk = ~clk;
    // A pin shows its driven level where enabled, the outside level else.
    assign pins = (gout & goe) | (ext & ~goe);

    ufg_host_model host (.clk(clk), .req(req), .rdata(rdata));
    ufg_regs dut (
        .CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
        .CTRL(ctrl), .FIFO_STAT(fifo), .FCR_LVL(fifo_control_reg), .LEVELS(levels),
        .GPIO_IN(pins), .GPIO_OUT(gout), .GPIO_OE(goe), .GPIO_IRQ(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(string n, logic e, logic g);
        chk_byte(n, {7'h00, e}, {7'h00, g});
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rd_chk(string n, logic [3:0] a, logic [7:0] e);
        host.rd(a, d);
        chk_byte(n, e, d);
    endtask

    // The request rises three edges after a pin change, four when latching, so twelve is ample.
    task automatic wait_irq(logic e);
        for (int i = 0; i < 12 && irq !== e; i++)
            cyc(1);
        chk_bit("irq", e, irq);
        if (irq !== e)
            test_done();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 0; a < 16; a++)
            if (a != 3 && a != 4)
                rd_chk("reset value", a[3:0], 8'h00);
        $display("test reset done");
    endtask

    task automatic t_scratch();
        host.wr(OFS_SCRATCH, 8'hA5);
        rd_chk("scratch", OFS_SCRATCH, 8'hA5);
        host.wr(OFS_SCRATCH, 8'h5A);
        rd_chk("scratch", OFS_SCRATCH, 8'h5A);
        chk_byte("oe", 8'h00, goe);
        chk_byte("halt", {2'h0, fifo_control_reg.rx}, {2'h0, levels.halt});
        $display("test scratch done");
    endtask

    task automatic t_thresh();
        for (int k = 1; k < 4; k++)
        begin
            ctrl.enhanced_function_enable_bit = k[0];
            ctrl.threshold_access_bit = k[1];
            host.wr(OFS_FLOW, 8'h3F);
            host.wr(OFS_TRIG, 8'h3F);
            if (k < 3)
            begin
                rd_chk("flow", OFS_FLOW, 8'h00);
                rd_chk("trig", OFS_TRIG, 8'h00);
                chk_byte("resume", {2'h0, fifo_control_reg.rx}, {2'h0, levels.resume});
            end
        end
        host.wr(OFS_FLOW, 8'hF3);
        rd_chk("flow", OFS_FLOW, 8'hF3);
        host.wr(OFS_FLOW, 8'h3F);
        cyc(1);
        chk_byte("halt", 8'h3C, {2'h0, levels.halt});
        chk_byte("resume", 8'h0C, {2'h0, levels.resume});
        host.wr(OFS_TRIG, 8'h50);
        cyc(1);
        chk_byte("rx trig", 8'h14, {2'h0, levels.rx_trig});
        chk_byte("tx trig", {2'h0, fifo_control_reg.tx}, {2'h0, levels.tx_trig});
        host.wr(OFS_TRIG, 8'h0F);
        cyc(1);
        chk_byte("rx trig", {2'h0, fifo_control_reg.rx}, {2'h0, levels.rx_trig});
        chk_byte("tx trig", 8'h3C, {2'h0, levels.tx_trig});
        ctrl.threshold_access_bit = 1'b0;
        host.wr(OFS_TRIG, 8'h11);
        rd_chk("trig", OFS_TRIG, 8'h0F);
        $display("test thresholds done");
    endtask

    task automatic t_counts();
        logic [6:0] tv[3] = '{7'h40, 7'h00, 7'h21};
        logic [6:0] rv[3] = '{7'h00, 7'h40, 7'h1F};
        for (int i = 0; i < 3; i++)
        begin
            fifo = '{tx_space: tv[i], rx_fill: rv[i]};
            rd_chk("tx space", OFS_TXSPACE, {1'b0, tv[i]});
            rd_chk("rx fill", OFS_RXFILL, {1'b0, rv[i]});
        end
        host.wr(OFS_TXSPACE, 8'hFF);
        rd_chk("tx space", OFS_TXSPACE, 8'h21);
        $display("test counts done");
    endtask

    task automatic t_pins();
        host.wr(OFS_PINDIR, 8'h0F);
        chk_byte("oe", 8'h0F, goe);
        ext = 8'hC3;
        host.wr(OFS_PINLVL, 8'hAA);
        chk_byte("drive", 8'h0A, gout & goe);
        cyc(3);
        rd_chk("pins", OFS_PINLVL, 8'hCA);
        host.wr(OFS_PINDIR, 8'h00);
        ext = 8'h00;
        cyc(4);
        rd_chk("pins", OFS_PINLVL, 8'h00);
        $display("test pins done");
    endtask

    task automatic t_irq();
        host.wr(OFS_PINIRQ, 8'h11);
        ext = 8'h01;
        wait_irq(1'b1);
        ext = 8'h00;
        wait_irq(1'b0);
        ext = 8'h02;
        cyc(8);
        chk_bit("masked", 1'b0, irq);
        ext = 8'h00;
        cyc(4);
        host.rd(OFS_PINLVL, d);
        ctrl.pin_function_control = 3'h1;
        ext = 8'h01;
        wait_irq(1'b1);
        ext = 8'h00;
        cyc(8);
        chk_bit("kept", 1'b1, irq);
        rd_chk("latched", OFS_PINLVL, 8'h01);
        wait_irq(1'b0);
        ctrl.pin_function_control = 3'h4;
        ext = 8'h01;
        cyc(8);
        chk_bit("modem", 1'b0, irq);
        ext = 8'h11;
        wait_irq(1'b1);
        ctrl.pin_function_control = 3'h6;
        wait_irq(1'b0);
        ctrl.modem_status_irq_enable = 1'b1;
        wait_irq(1'b1);
        $display("test irq done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        ext = '0;
        ctrl = '0;
        fifo = '0;
        fifo_control_reg = '{rx: 6'h08, tx: 6'h10};
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        cyc(1);
        t_reset();
        t_scratch();
        t_thresh();
        t_counts();
        t_pins();
        t_irq();
        test_done();
    end
endmodule

// ---- testbench/ufg_host_model.sv ----
// Host model that issues single byte writes and reads on the register port.
`timescale 1ns/1ps
module ufg_host_model
    import ufg_pkg::*;
(
    // Clock.
    input  wire logic              clk,
    // Register port.
    output ufg_req_t               req,
    input  wire logic [DATA_W-1:0] rdata
);
    initial req = '0;

    // A request rises just after an edge and drops after the taking edge.
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 req = '0;
    endtask

    task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 d = rdata;
        req = '0;
    endtask
endmodule

// ---- testbench/ufg_regs_monitor.sv ----
// Port-level assertions of the extended register bank, bound to its top.
`timescale 1ns/1ps
module ufg_regs_monitor
    import ufg_pkg::*;
(
    // Clock and reset.
    input wire logic              CLK,
    input wire logic              RST_N,
    // Register port and control bits.
    input wire ufg_req_t          REG_REQ,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire ufg_ctrl_t         CTRL,
    // FIFO side.
    input wire ufg_fifo_t         FIFO_STAT,
    input wire ufg_fcr_lvl_t      FCR_LVL,
    input wire ufg_levels_t       LEVELS,
    // Pins.
    input wire logic [PIN_W-1:0]  GPIO_IN,
    input wire logic [PIN_W-1:0]  GPIO_OUT,
    input wire logic [PIN_W-1:0]  GPIO_OE,
    input wire logic              GPIO_IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////
    wire unlock = CTRL.enhanced_function_enable_bit
                  && CTRL.threshold_access_bit;

    // Expected level of one nibble; z marks the fall-back case.
    function automatic logic [5:0] lvl(logic z, logic [3:0] n,
                                       logic [5:0] f);
        return z ? f : {n, 2'h0};
    endfunction

    sequence s_wr(logic [ADDR_W-1:0] a);
        REG_REQ.wr && REG_REQ.addr == a;
    endsequence
    sequence s_rd(logic [ADDR_W-1:0] a);
        REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == a;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_scratch_readback:
        assert property (s_wr(OFS_SCRATCH) ##1 !REG_REQ.wr
            ##1 s_rd(OFS_SCRATCH) |=> REG_RDATA == $past(REG_REQ.wdata, 3))
        else $error("scratch readback differs");
    a_flow_levels:
        assert property (s_wr(OFS_FLOW) ##0 unlock |-> ##2
            LEVELS.halt == lvl($past(REG_REQ.wdata, 2) == 8'h00,
                $past(REG_REQ.wdata[3:0], 2), $past(FCR_LVL.rx))
            && LEVELS.resume == lvl($past(REG_REQ.wdata, 2) == 8'h00,
                $past(REG_REQ.wdata[7:4], 2), $past(FCR_LVL.rx)))
        else $error("flow levels wrong");
    a_trig_levels:
        assert property (s_wr(OFS_TRIG) ##0 unlock |-> ##2
            LEVELS.rx_trig == lvl($past(REG_REQ.wdata[7:4], 2) == 4'h0,
                $past(REG_REQ.wdata[7:4], 2), $past(FCR_LVL.rx))
            && LEVELS.tx_trig == lvl($past(REG_REQ.wdata[3:0], 2) == 4'h0,
                $past(REG_REQ.wdata[3:0], 2), $past(FCR_LVL.tx)))
        else $error("trigger levels wrong");
    a_locked_keep:
        assert property ((REG_REQ.wr && !unlock && (REG_REQ.addr == OFS_FLOW
            || REG_REQ.addr == OFS_TRIG)) ##1 $stable(FCR_LVL)
            |=> $stable(LEVELS))
        else $error("locked write moved levels");
    a_tx_space_read:
        assert property (s_rd(OFS_TXSPACE)
            |=> REG_RDATA == {1'b0, $past(FIFO_STAT.tx_space)})
        else $error("tx space read wrong");
    a_rx_fill_read:
        assert property (s_rd(OFS_RXFILL)
            |=> REG_RDATA == {1'b0, $past(FIFO_STAT.rx_fill)})
        else $error("rx fill read wrong");
    a_dir_to_enable:
        assert property (s_wr(OFS_PINDIR) |=> GPIO_OE == $past(REG_REQ.wdata))
        else $error("pin enables differ from direction");
    a_level_to_out:
        assert property (s_wr(OFS_PINLVL) |=> GPIO_OUT == $past(REG_REQ.wdata))
        else $error("pin outputs differ from written level");
endmodule

bind ufg_regs ufg_regs_monitor u_mon (
    .CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .CTRL(CTRL), .FIFO_STAT(FIFO_STAT), .FCR_LVL(FCR_LVL), .LEVELS(LEVELS),
    .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
    .GPIO_IRQ(GPIO_IRQ));
